/* File: tb/radio_status_register_bank_test.sv */
// Self-checking bench for the radio status register bank
module radio_status_register_bank_test
  import rsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clk;
  logic          sys_rst;
  rsr_core_t     core;
  rsr_fifo_cal_t fc;
  logic          rd_en;
  logic [5:0]    rd_addr;
  logic [7:0]    rd_data;
  logic          rd_valid;
  logic          rd_miss;
  logic [15:0]   lf;
  logic          crc_e;
  logic          sync_e;
  logic [6:0]    hi_e;
  logic [6:0]    lo_e;
  int            bad_count;
  int            checks_done;
  int            cycles;
  logic [14:0]   sc [6];

  rsr_status_bank rsr_status_bank_i (.clk(clk), .sys_rst(sys_rst), .core_in(core),
    .fifo_cal_in(fc), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_miss(rd_miss));
  rsr_host_model rsr_host_model_i (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_miss(rd_miss));

  always #5 clk = ~clk;

  function automatic logic [7:0] rnd();
    repeat (8) lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction

  function automatic logic [8:0] exp_reg(logic [5:0] a);
    case (a)
      RSR_ADDR_PKT_STATUS: return {1'b0, crc_e, core.carrier_sense, core.preamble_quality_met,
        core.channel_clear, sync_e, core.gp_output_two_level, 1'b0, core.gp_output_zero_level};
      RSR_ADDR_TUNING:     return {1'b0, fc.synth_tuning_value};
      RSR_ADDR_TX_LEVEL:   return {1'b0, fc.tx_queue_underrun, fc.tx_queue_count};
      RSR_ADDR_RX_LEVEL:   return {1'b0, fc.rx_queue_overrun, fc.rx_queue_count};
      RSR_ADDR_CAL_HIGH:   return {2'b00, hi_e};
      RSR_ADDR_CAL_LOW:    return {2'b00, lo_e};
      default:             return 9'h100;
    endcase
  endfunction

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_reg(input logic [5:0] a);
    logic [7:0] d;
    logic       m;
    rsr_host_model_i.read(a, d, m);
    check({m, d}, exp_reg(a));
  endtask

  // One-cycle event pulse; levels survive the mask
  // An edge passes first so back-to-back pulses never merge into one
  task automatic fire(input logic [13:0] ev);
    @(posedge clk);
    #1;
    core = rsr_core_t'(core | ev);
    @(posedge clk);
    #1;
    core = rsr_core_t'(core & 14'h103f);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    core = '0;
    fc = '0;
    lf = 16'h002c;
    {crc_e, sync_e, hi_e, lo_e} = '0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    // Receive flag in bit 14, packet end and abort events below
    sc = '{15'h4100, 15'h4080, 15'h4040, 15'h0040, 15'h0100, 15'h0200};
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int a = 'h37; a <= 'h3e; a++) chk_reg(6'(a));
    core.checksum_match = 1'b1;
    fire(14'h2000);
    crc_e = 1'b1;
    chk_reg(RSR_ADDR_PKT_STATUS);
    fire(14'h0800);
    crc_e = 1'b0;
    chk_reg(RSR_ADDR_PKT_STATUS);
    fire(14'h2800);
    chk_reg(RSR_ADDR_PKT_STATUS);
    fire(14'h2000);
    core.checksum_match = 1'b0;
    fire(14'h2000);
    chk_reg(RSR_ADDR_PKT_STATUS);
    foreach (sc[i]) begin
      core.receiving = sc[i][14];
      fire(14'h0400);
      sync_e = 1'b1;
      chk_reg(RSR_ADDR_PKT_STATUS);
      fire(sc[i][13:0]);
      sync_e = !(sc[i][9] || (sc[i][14] && (sc[i][8] || sc[i][7])) || (!sc[i][14] && sc[i][6]));
      chk_reg(RSR_ADDR_PKT_STATUS);
      fire(14'h0200);
      sync_e = 1'b0;
    end
    repeat (30) begin
      {fc.tx_queue_underrun, fc.tx_queue_count} = rnd();
      {fc.rx_queue_overrun, fc.rx_queue_count} = rnd();
      fc.synth_tuning_value = rnd();
      {core.carrier_sense, core.preamble_quality_met, core.channel_clear,
       core.gp_output_two_level, core.gp_output_zero_level} = 5'(rnd());
      for (int a = 'h38; a <= 'h3b; a++) chk_reg(6'(a));
    end
    {hi_e, lo_e} = 14'(rnd() * 77);
    {fc.slow_osc_cal_high_value, fc.slow_osc_cal_low_value} = {hi_e, lo_e};
    fc.cal_done = 1'b1;
    @(posedge clk);
    #1;
    fc.cal_done = 1'b0;
    // Later values without a finished run must not show
    {fc.slow_osc_cal_high_value, fc.slow_osc_cal_low_value} = ~{hi_e, lo_e};
    chk_reg(RSR_ADDR_CAL_HIGH);
    chk_reg(RSR_ADDR_CAL_LOW);
    core.checksum_match = 1'b1;
    fire(14'h2400);
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    {crc_e, sync_e, hi_e, lo_e} = '0;
    for (int a = 'h38; a <= 'h3d; a++) chk_reg(6'(a));
    finish_test();
  end
endmodule // radio_status_register_bank_test

/* File: tb/rsr_host_model.sv */
// Host model issuing single register reads on the status read port
module rsr_host_model
  import rsr_pkg::*;
(
  input  wire logic       clk,
  output logic            rd_en,
  output logic [5:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  input  wire logic       rd_miss
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    rd_en = 1'b0;
    rd_addr = 6'h00;
  end

  // Plain status reads only, never a lock poll on the pin bits
  task automatic read(input logic [5:0] addr, output logic [7:0] data, output logic miss);
    int n;
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    rd_addr = addr;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    // Stale address would hide a decoder that samples late
    rd_addr = ~addr;
    n = 0;
    while (rd_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    data = rd_data;
    miss = rd_miss;
    // No answer at all: poison the data so the compare cannot pass
    if (rd_valid !== 1'b1) begin
      data = 8'hxx;
    end
  endtask
endmodule // rsr_host_model

/* File: verilog/rsr_pkg.sv */
// Package: offsets, field positions and types for the radio status bank
package rsr_pkg;
  localparam logic [5:0] RSR_ADDR_PKT_STATUS = 6'h38;
  localparam logic [5:0] RSR_ADDR_TUNING     = 6'h39;
  localparam logic [5:0] RSR_ADDR_TX_LEVEL   = 6'h3a;
  localparam logic [5:0] RSR_ADDR_RX_LEVEL   = 6'h3b;
  localparam logic [5:0] RSR_ADDR_CAL_HIGH   = 6'h3c;
  localparam logic [5:0] RSR_ADDR_CAL_LOW    = 6'h3d;
  localparam int RSR_BIT_CHECKSUM_OK  = 7;
  localparam int RSR_BIT_CARRIER      = 6;
  localparam int RSR_BIT_PREAMBLE     = 5;
  localparam int RSR_BIT_CLEAR        = 4;
  localparam int RSR_BIT_SYNC         = 3;
  localparam int RSR_BIT_PIN_TWO      = 2;
  localparam int RSR_BIT_PIN_ZERO     = 0;
  localparam int RSR_BIT_FLAG         = 7;
  localparam logic [7:0] RSR_RESET_BYTE    = 8'h00;
  localparam logic [7:0] RSR_LOCK_FUNCTION = 8'h0a;
  localparam int RSR_NUM_REGS = 6;

  // Live events and levels from the radio core
  typedef struct packed {
    logic       checksum_done;
    logic       checksum_match;
    logic       rx_enter;
    logic       sync_event;
    logic       packet_end;
    logic       addr_check_fail;
    logic       rx_overrun_enter;
    logic       tx_underrun_enter;
    logic       receiving;
    logic       carrier_sense;
    logic       preamble_quality_met;
    logic       channel_clear;
    logic       gp_output_two_level;
    logic       gp_output_zero_level;
  } rsr_core_t;

  typedef struct packed {
    logic       tx_queue_underrun;
    logic [6:0] tx_queue_count;
    logic       rx_queue_overrun;
    logic [6:0] rx_queue_count;
    logic [7:0] synth_tuning_value;
    logic       cal_done;
    logic [6:0] slow_osc_cal_high_value;
    logic [6:0] slow_osc_cal_low_value;
  } rsr_fifo_cal_t;

  typedef enum logic [1:0] {RSR_SYNC_IDLE, RSR_SYNC_RX, RSR_SYNC_TX} rsr_sync_state_t;
endpackage

/* File: verilog/rsr_reg_mem.sv */
// Small register file holding the status bytes, registered read port
module rsr_reg_mem
  import rsr_pkg::*;
#(
  parameter int DEPTH = RSR_NUM_REGS,
  parameter int WIDTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [DEPTH*WIDTH-1:0]   wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_nxt;

  always_comb begin
    rd_nxt = mem_r[rd_idx];
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          mem_r[i] <= '0;
        end else begin
          mem_r[i] <= wr_data[i*WIDTH +: WIDTH];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_nxt;
    end
  end
endmodule // rsr_reg_mem

/* File: verilog/rsr_status_bank.sv */
// Read-only radio status register bank, addresses 0x38 to 0x3d
module rsr_status_bank
  import rsr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire rsr_core_t     core_in,
  input  wire rsr_fifo_cal_t fifo_cal_in,
  input  wire logic          rd_en,
  input  wire logic [5:0]    rd_addr,
  output logic [7:0]         rd_data,
  output logic               rd_valid,
  output logic               rd_miss
);
  rsr_sync_state_t sync_r, sync_nxt;
  logic            crc_ok_r, crc_ok_nxt;
  logic [6:0]      cal_hi_r, cal_hi_nxt;
  logic [6:0]      cal_lo_r, cal_lo_nxt;
  logic [7:0]      pkt_byte;
  logic [2:0]      rd_idx;
  logic            hit;
  logic            rd_valid_nxt, rd_miss_nxt;
  logic [7:0]      rd_data_nxt;
  logic [7:0]      mem_q;
  logic            miss_r;
  logic [6*8-1:0]  bank_bytes;

  // Checksum flag; clear on receive entry wins over a simultaneous result
  always_comb begin
    crc_ok_nxt = crc_ok_r;
    if (core_in.rx_enter) begin
      crc_ok_nxt = 1'b0;
    end else if (core_in.checksum_done) begin
      crc_ok_nxt = core_in.checksum_match;
    end
  end

  // Sync indication follows the packet, and direction picks the abort cause
  always_comb begin
    sync_nxt = sync_r;
    case (sync_r)
      RSR_SYNC_IDLE: begin
        if (core_in.sync_event) begin
          sync_nxt = core_in.receiving ? RSR_SYNC_RX : RSR_SYNC_TX;
        end
      end
      RSR_SYNC_RX: begin
        if (core_in.packet_end || core_in.addr_check_fail || core_in.rx_overrun_enter) begin
          sync_nxt = RSR_SYNC_IDLE;
        end
      end
      RSR_SYNC_TX: begin
        if (core_in.packet_end || core_in.tx_underrun_enter) begin
          sync_nxt = RSR_SYNC_IDLE;
        end
      end
      default: sync_nxt = RSR_SYNC_IDLE;
    endcase
  end

  // Calibration results held until the next run completes
  always_comb begin
    cal_hi_nxt = cal_hi_r;
    cal_lo_nxt = cal_lo_r;
    if (fifo_cal_in.cal_done) begin
      cal_hi_nxt = fifo_cal_in.slow_osc_cal_high_value;
      cal_lo_nxt = fifo_cal_in.slow_osc_cal_low_value;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_r   <= RSR_SYNC_IDLE;
      crc_ok_r <= 1'b0;
      cal_hi_r <= 7'h00;
      cal_lo_r <= 7'h00;
    end else begin
      sync_r   <= sync_nxt;
      crc_ok_r <= crc_ok_nxt;
      cal_hi_r <= cal_hi_nxt;
      cal_lo_r <= cal_lo_nxt;
    end
  end

  // Pin levels are tapped before the output inverters, so inversion never shows
  always_comb begin
    pkt_byte = RSR_RESET_BYTE;
    pkt_byte[RSR_BIT_CHECKSUM_OK] = crc_ok_r;
    pkt_byte[RSR_BIT_CARRIER]     = core_in.carrier_sense;
    pkt_byte[RSR_BIT_PREAMBLE]    = core_in.preamble_quality_met;
    pkt_byte[RSR_BIT_CLEAR]       = core_in.channel_clear;
    pkt_byte[RSR_BIT_SYNC]        = (sync_r != RSR_SYNC_IDLE);
    pkt_byte[RSR_BIT_PIN_TWO]     = core_in.gp_output_two_level;
    pkt_byte[RSR_BIT_PIN_ZERO]    = core_in.gp_output_zero_level;
  end

  // Snapshot order by index: entry 0 at 0x38 upward
  always_comb begin
    bank_bytes = {
      {1'b0, cal_lo_r},
      {1'b0, cal_hi_r},
      {fifo_cal_in.rx_queue_overrun, fifo_cal_in.rx_queue_count},
      {fifo_cal_in.tx_queue_underrun, fifo_cal_in.tx_queue_count},
      fifo_cal_in.synth_tuning_value,
      pkt_byte
    };
  end

  // Address decode; one cycle in memory plus one in output stage
  always_comb begin
    hit    = 1'b0;
    rd_idx = 3'd0;
    if (rd_addr == RSR_ADDR_PKT_STATUS) begin
      hit = 1'b1; rd_idx = 3'd0;
    end else if (rd_addr == RSR_ADDR_TUNING) begin
      hit = 1'b1; rd_idx = 3'd1;
    end else if (rd_addr == RSR_ADDR_TX_LEVEL) begin
      hit = 1'b1; rd_idx = 3'd2;
    end else if (rd_addr == RSR_ADDR_RX_LEVEL) begin
      hit = 1'b1; rd_idx = 3'd3;
    end else if (rd_addr == RSR_ADDR_CAL_HIGH) begin
      hit = 1'b1; rd_idx = 3'd4;
    end else if (rd_addr == RSR_ADDR_CAL_LOW) begin
      hit = 1'b1; rd_idx = 3'd5;
    end
  end

  rsr_reg_mem #(
    .DEPTH (RSR_NUM_REGS),
    .WIDTH (8)
  ) u_mem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_data (bank_bytes),
    .rd_idx  (rd_idx),
    .rd_data (mem_q)
  );

  // Memory already adds one cycle; the answer comes two edges after the request
  logic rd_pend_r;
  always_comb begin
    rd_valid_nxt = rd_pend_r;
    rd_miss_nxt  = rd_pend_r & miss_r;
    // Unmapped reads forced to zero so a stale memory word never leaks out
    rd_data_nxt  = miss_r ? 8'h00 : mem_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_pend_r <= 1'b0;
      miss_r    <= 1'b0;
      rd_valid  <= 1'b0;
      rd_miss   <= 1'b0;
      rd_data   <= 8'h00;
    end else begin
      rd_pend_r <= rd_en;
      miss_r    <= ~hit;
      rd_valid  <= rd_valid_nxt;
      rd_miss   <= rd_miss_nxt;
      rd_data   <= rd_data_nxt;
    end
  end

  // Checks; a read answers with the bank as captured one edge before its request edge
  a_crc_clear_rx: assert property (@(posedge clk) disable iff (sys_rst)
    core_in.rx_enter |=> !crc_ok_r) else $error("checksum flag not cleared");
  a_crc_latch: assert property (@(posedge clk) disable iff (sys_rst)
    (core_in.checksum_done && !core_in.rx_enter) |=>
    crc_ok_r == $past(core_in.checksum_match)) else $error("checksum result not latched");
  a_sync_rise: assert property (@(posedge clk) disable iff (sys_rst)
    (sync_r == RSR_SYNC_IDLE && core_in.sync_event) |=> sync_r != RSR_SYNC_IDLE)
    else $error("sync not raised");
  a_sync_end_pkt: assert property (@(posedge clk) disable iff (sys_rst)
    core_in.packet_end |=> sync_r == RSR_SYNC_IDLE) else $error("sync not dropped");
  a_sync_rx_abort: assert property (@(posedge clk) disable iff (sys_rst)
    (sync_r == RSR_SYNC_RX && (core_in.addr_check_fail || core_in.rx_overrun_enter))
    |=> sync_r == RSR_SYNC_IDLE) else $error("rx abort ignored");
  a_sync_tx_abort: assert property (@(posedge clk) disable iff (sys_rst)
    (sync_r == RSR_SYNC_TX && core_in.tx_underrun_enter) |=> sync_r == RSR_SYNC_IDLE)
    else $error("tx abort ignored");
  a_pin_two_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == RSR_ADDR_PKT_STATUS) |=> ##1
    rd_valid && rd_data[RSR_BIT_PIN_TWO] == $past(core_in.gp_output_two_level, 3))
    else $error("pin two read wrong");
  a_pin_zero_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == RSR_ADDR_PKT_STATUS) |=> ##1
    rd_data[RSR_BIT_PIN_ZERO] == $past(core_in.gp_output_zero_level, 3) && !rd_data[1])
    else $error("pin zero read wrong");
  a_channel_state_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == RSR_ADDR_PKT_STATUS) |=> ##1
    rd_data[RSR_BIT_CARRIER:RSR_BIT_CLEAR] == $past({core_in.carrier_sense,
    core_in.preamble_quality_met, core_in.channel_clear}, 3))
    else $error("channel state read wrong");
  a_tx_level_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == RSR_ADDR_TX_LEVEL) |=> ##1
    rd_data == $past({fifo_cal_in.tx_queue_underrun, fifo_cal_in.tx_queue_count}, 3))
    else $error("tx level wrong");
  a_rx_level_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == RSR_ADDR_RX_LEVEL) |=> ##1
    rd_data == $past({fifo_cal_in.rx_queue_overrun, fifo_cal_in.rx_queue_count}, 3))
    else $error("rx level wrong");
  a_cal_hold: assert property (@(posedge clk) disable iff (sys_rst)
    fifo_cal_in.cal_done |=> cal_hi_r == $past(fifo_cal_in.slow_osc_cal_high_value) &&
    cal_lo_r == $past(fifo_cal_in.slow_osc_cal_low_value))
    else $error("cal result not held");
  a_cal_high_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == RSR_ADDR_CAL_HIGH) |=> ##1
    rd_data == {1'b0, $past(cal_hi_r, 3)}) else $error("cal high read wrong");
  a_tuning_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == RSR_ADDR_TUNING) |=> ##1
    rd_data == $past(fifo_cal_in.synth_tuning_value, 3)) else $error("tuning wrong");

  c_rx_packet: cover property (@(posedge clk) sync_r == RSR_SYNC_RX ##[1:20] sync_r == RSR_SYNC_IDLE);
  c_tx_abort: cover property (@(posedge clk) sync_r == RSR_SYNC_TX && core_in.tx_underrun_enter);
  c_miss: cover property (@(posedge clk) rd_miss);
  c_crc_ok: cover property (@(posedge clk) crc_ok_r);
endmodule // rsr_status_bank
